/* File: tb_top.sv */
// Purpose: self-checking bench of the status and flow threshold block
// Assumes: 25 MHz clock, bit_tick held high in the break test to shorten bit times
// Notes: comb outputs are sampled 1 ns after a clock edge, in sc two edges after the one that set inputs
`timescale 1ns/1ps
module tb_top;
	logic clk, rstn, reg_wr, reg_rd, enh_enable, auto_cts_en, auto_rts_en;
	logic sw_flow_en, modem_irq_en, fifo_en, mctl_dtr, mctl_rts, mctl_op1;
	logic mctl_op2, loopback, bit_tick, rx_char_done, head_par_err;
	logic head_frm_err, head_brk, hold_full, shift_busy;
	logic cts_n, dsr_n, ring_indicator_n, carrier_detect_n, rx_pin;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, msk, cnt;
	logic [1:0] fctl_tx_trig, fctl_rx_trig;
	logic [3:0] frame_bits;
	logic [6:0] rx_count, rx_tagged_count, tx_count;
	logic baud_clk_en, rx_push, brk_push, tx_hold, rts_halt, xoff_req;
	logic xon_req, modem_irq, tx_ready_irq, rx_data_irq, rx_timeout_irq;
	logic [6:0] rxt [4] = '{7'h08, 7'h10, 7'h38, 7'h3c};
	logic [6:0] txt [4] = '{7'h08, 7'h10, 7'h20, 7'h38};
	logic [6:0] lvc [5] = '{7'h04, 7'h0b, 7'h0c, 7'h05, 7'h04};
	logic lve [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	int error_cnt = 0;
	int compares = 0;

	// ****************************************
	// design and partner
	// ****************************************
	uss_status_flow dut (.clk, .rstn, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .reg_rdata, .enh_enable, .auto_cts_en, .auto_rts_en,
		.sw_flow_en, .modem_irq_en, .fifo_en, .fctl_tx_trig, .fctl_rx_trig,
		.mctl_dtr, .mctl_rts, .mctl_op1, .mctl_op2, .loopback, .cts_n, .dsr_n,
		.ring_indicator_n, .carrier_detect_n, .rx_pin, .bit_tick,
		.frame_bits, .rx_count, .rx_char_done, .head_par_err, .head_frm_err,
		.head_brk, .rx_tagged_count, .tx_count, .hold_full, .shift_busy,
		.baud_clk_en, .rx_push, .brk_push, .tx_hold, .rts_halt, .xoff_req,
		.xon_req, .modem_irq, .tx_ready_irq, .rx_data_irq, .rx_timeout_irq);
	uss_line_peer peer (.clk, .cts_n, .dsr_n, .ring_indicator_n,
		.carrier_detect_n, .rx_pin);

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic print_verdict();
		if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wt(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : wt

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk) reg_wr <= 1'b0;
	endtask : wr

	// read data is taken 1 ns after the edge that sampled the strobe
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk) reg_rd <= 1'b0;
		#1 chk(reg_rdata & msk, exp);
	endtask : rd

	task automatic sc(input logic [6:0] r, input logic [6:0] t,
		input logic [1:0] e);
		@(posedge clk) {rx_count, tx_count} <= {r, t};
		wt(2);
		chk({6'h00, rx_data_irq, tx_ready_irq}, {6'h00, e});
	endtask : sc

	task automatic pulse_done(input logic [6:0] c, input logic e);
		@(posedge clk) {rx_count, rx_char_done} <= {c, 1'b1};
		#1 chk(8'(rx_push), 8'(e));
		@(posedge clk) rx_char_done <= 1'b0;
	endtask : pulse_done

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs();
		@(posedge clk) mctl_op1 <= 1'b1;
		rd(3'h7, 8'hff);
		wr(3'h6, 8'h23);
		rd(3'h6, 8'h00);
		wr(3'h7, 8'h5a);
		rd(3'h7, 8'h5a);
		rd(3'h3, 8'h00);
		wr(3'h4, 8'h80);
		rd(3'h4, 8'h00);
		@(posedge clk) enh_enable <= 1'b1;
		wr(3'h4, 8'h80);
		rd(3'h4, 8'h80);
		cnt = 8'h00;
		repeat (8) begin
			wt(1);
			cnt = cnt + 8'(baud_clk_en);
		end
		chk(cnt, 8'h02);
		wr(3'h4, 8'h00);
	endtask : t_regs

	task automatic t_line();
		rd(3'h5, 8'h60);
		@(posedge clk) {rx_count, tx_count, rx_tagged_count} <= 21'h004081;
		head_par_err <= 1'b1;
		rd(3'h5, 8'h85);
		@(posedge clk) {head_par_err, head_frm_err} <= 2'b01;
		{tx_count, shift_busy} <= {7'h00, 1'b1};
		rd(3'h5, 8'ha9);
		@(posedge clk) {head_frm_err, shift_busy, rx_tagged_count} <= 9'h0;
		pulse_done(7'h0a, 1'b1);
		pulse_done(7'h40, 1'b0);
		rd(3'h5, 8'h63);
		rd(3'h5, 8'h61);
		@(posedge clk) {fifo_en, hold_full} <= 2'b01;
		rd(3'h5, 8'h01);
		@(posedge clk) {fifo_en, hold_full} <= 2'b10;
	endtask : t_line

	task automatic t_modem();
		@(posedge clk) mctl_op1 <= 1'b0;
		modem_irq_en <= 1'b1;
		peer.drive(4'he, 1'b1);
		wt(6);
		chk(8'(modem_irq), 8'h01);
		rd(3'h6, 8'h11);
		rd(3'h6, 8'h10);
		chk(8'(modem_irq), 8'h00);
		peer.drive(4'ha, 1'b1);
		wt(6);
		rd(3'h6, 8'h50);
		peer.drive(4'he, 1'b1);
		wt(6);
		rd(3'h6, 8'h14);
		@(posedge clk) {loopback, mctl_rts, mctl_dtr, mctl_op2} <= 4'hf;
		msk = 8'hf0;
		wt(6);
		rd(3'h6, 8'hb0);
		@(posedge clk) {loopback, mctl_rts, mctl_dtr, mctl_op2} <= 4'h0;
		wt(6);
		rd(3'h6, 8'h10);
		msk = 8'hff;
		@(posedge clk) auto_cts_en <= 1'b1;
		wt(6);
		chk(8'(tx_hold), 8'h00);
		peer.drive(4'hf, 1'b1);
		wt(6);
		chk(8'(tx_hold), 8'h01);
	endtask : t_modem

	task automatic t_levels();
		@(posedge clk) {mctl_op1, auto_rts_en, sw_flow_en} <= 3'b111;
		// halt 4 above and resume 4 below the receive trigger of 8
		wr(3'h6, 8'h13);
		rd(3'h6, 8'h13);
		for (int i = 0; i < 5; i++) begin
			sc(lvc[i], 7'h00, {lvc[i] >= uss_pkg::RX_TRIG_0, 1'b1});
			chk(8'(rts_halt), 8'(lve[i]));
		end
		@(posedge clk) rx_count <= 7'h0c;
		#1 chk(8'({xoff_req, xon_req}), 8'h02);
		@(posedge clk) rx_count <= 7'h04;
		#1 chk(8'({xoff_req, xon_req}), 8'h01);
	endtask : t_levels

	task automatic t_trig();
		wr(3'h7, 8'h21);
		rd(3'h7, 8'h21);
		sc(7'h07, 7'h3c, 2'b01);
		sc(7'h08, 7'h3d, 2'b10);
		wr(3'h7, 8'h00);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk) {fctl_rx_trig, fctl_tx_trig} <= {2'(k), 2'(k)};
			sc(rxt[k] - 7'h01, 7'h40 - txt[k], 2'b01);
			sc(rxt[k], 7'h41 - txt[k], 2'b10);
		end
		@(posedge clk) mctl_op1 <= 1'b0;
		rd(3'h7, 8'h5a);
	endtask : t_trig

	task automatic t_break();
		@(posedge clk) {bit_tick, frame_bits, rx_count} <= 12'hc40;
		peer.drive(4'hf, 1'b0);
		cnt = 8'h00;
		repeat (20) begin
			wt(1);
			cnt = cnt + 8'(brk_push);
		end
		chk(cnt, 8'h01);
		peer.drive(4'hf, 1'b1);
		sc(7'h01, 7'h00, 2'b01);
		chk(8'(rx_timeout_irq), 8'h00);
		wt(50);
		chk(8'(rx_timeout_irq), 8'h01);
	endtask : t_break

	// ****************************************
	// clock, reset, run and watchdog
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		{rstn, reg_wr, reg_rd, enh_enable, auto_cts_en, auto_rts_en} = '0;
		{sw_flow_en, modem_irq_en, mctl_dtr, mctl_rts, mctl_op1} = '0;
		{mctl_op2, loopback, bit_tick, rx_char_done, head_par_err} = '0;
		{head_frm_err, head_brk, hold_full, shift_busy} = '0;
		{reg_addr, reg_wdata, fctl_tx_trig, fctl_rx_trig} = '0;
		{rx_count, rx_tagged_count, tx_count} = '0;
		{fifo_en, frame_bits, msk} = {1'b1, 4'h8, 8'hff};
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		wt(6);
		t_regs();
		t_line();
		t_modem();
		t_levels();
		t_trig();
		t_break();
		print_verdict();
	end

	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		print_verdict();
	end
endmodule : tb_top

/* File: uss_line_peer.sv */
// Purpose: remote modem and serial line partner of the status block
// Assumes: pins are active low and the serial line idles high
// Notes: pins change only just after a rising clock edge
`timescale 1ns/1ps
module uss_line_peer (
	input wire logic clk,
	output logic cts_n,
	output logic dsr_n,
	output logic ring_indicator_n,
	output logic carrier_detect_n,
	output logic rx_pin
);
	// ****************************************
	// pin drive
	// ****************************************
	// every pin starts inactive so no delta is seen at power up
	initial begin
		{carrier_detect_n, ring_indicator_n, dsr_n, cts_n} = 4'hf;
		rx_pin = 1'b1;
	end

	// m[0] cts, m[1] dsr, m[2] ring, m[3] carrier; high cts stops sender
	task automatic drive(input logic [3:0] m, input logic r);
		@(posedge clk);
		{carrier_detect_n, ring_indicator_n, dsr_n, cts_n} <= m;
		rx_pin <= r;
	endtask : drive
endmodule : uss_line_peer

/* File: uss_modem_bit.sv */
// Purpose: one modem input: synchroniser, level, sticky delta
// Assumes: pin_n is asynchronous and active low
// Notes: deltas are held off until the synchroniser has filled
`timescale 1ns/1ps
module uss_modem_bit (
	input wire logic clk,
	input wire logic rstn,
	input wire logic pin_n,
	input wire logic loop,
	input wire logic loop_lvl,
	input wire logic rise_only,
	input wire logic clr,
	output logic lvl,
	output logic delta
);

	typedef struct packed {
		logic [1:0] sync;
		logic [1:0] prime;
		logic lvl;
		logic delta;
	} uss_mb_state_t;

	uss_mb_state_t s_q;
	uss_mb_state_t s_d;
	logic new_lvl;
	logic change;

	always_comb begin
		s_d = s_q;
		s_d.sync = {s_q.sync[0], pin_n};
		new_lvl = loop ? loop_lvl : ~s_q.sync[1];
		// ring delta only when the pin goes low to high
		change = (s_q.prime == uss_pkg::PRIME_DONE) &&
			(new_lvl != s_q.lvl) && (!rise_only || !new_lvl);
		if (s_q.prime != uss_pkg::PRIME_DONE)
			s_d.prime = s_q.prime + 2'h1;
		s_d.lvl = new_lvl;
		// a change in the clearing cycle still sets the flag
		if (change)
			s_d.delta = 1'b1;
		else if (clr)
			s_d.delta = 1'b0;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign lvl = s_q.lvl;
	assign delta = s_q.delta;

	chk_delta_sets: assert property (@(posedge clk) disable iff (!rstn)
		change |=> delta)
		else $error("delta not set after input change");
	chk_ring_edge: assert property (@(posedge clk) disable iff (!rstn)
		rise_only && !$past(delta) && delta |-> !lvl)
		else $error("ring delta set on wrong edge");

endmodule : uss_modem_bit

/* File: uss_pkg.sv */
// Purpose: shared constants and types of the uart status and flow block
// Assumes: one 25 MHz clock, 64-entry fifos in the surrounding datapath
// Notes: offsets are the 3-bit register addresses of one channel
package uss_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [2:0] OFS_MODEM_CONTROL = 3'h4;
	localparam logic [2:0] OFS_LINE_STATUS = 3'h5;
	localparam logic [2:0] OFS_MODEM_STATUS = 3'h6;
	localparam logic [2:0] OFS_SCRATCH = 3'h7;

	// ****************************************
	// fields and reset values
	// ****************************************
	localparam int PRESC_BIT = 7;
	localparam logic [7:0] SCRATCH_RESET = 8'hff;
	localparam logic [7:0] LEVELS_RESET = 8'h00;
	localparam logic [1:0] PRESC_LAST = 2'h3;
	localparam logic [6:0] FIFO_DEPTH = 7'h40;
	localparam logic [1:0] PRIME_DONE = 2'h3;

	// fallback trigger tables, indexed by the 2-bit fifo control field
	localparam logic [6:0] TX_TRIG_0 = 7'h08;
	localparam logic [6:0] TX_TRIG_1 = 7'h10;
	localparam logic [6:0] TX_TRIG_2 = 7'h20;
	localparam logic [6:0] TX_TRIG_3 = 7'h38;
	localparam logic [6:0] RX_TRIG_0 = 7'h08;
	localparam logic [6:0] RX_TRIG_1 = 7'h10;
	localparam logic [6:0] RX_TRIG_2 = 7'h38;
	localparam logic [6:0] RX_TRIG_3 = 7'h3c;

	// receive idle time before a timeout, in bit times
	localparam logic [7:0] RX_TIMEOUT_BITS = 8'h28;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		USS_BRK_IDLE = 2'b00,
		USS_BRK_LOW = 2'b01,
		USS_BRK_HELD = 2'b11
	} uss_brk_t;

endpackage : uss_pkg

/* File: uss_status_flow.sv */
// Purpose: status, modem input and flow threshold logic of one channel
// Assumes: fifo, shifter and baud datapaths sit outside, on clk
// Notes: registers sit behind a plain strobe port with 3-bit offsets
`timescale 1ns/1ps
module uss_status_flow (
	input wire logic clk,
	input wire logic rstn,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic enh_enable,
	input wire logic auto_cts_en,
	input wire logic auto_rts_en,
	input wire logic sw_flow_en,
	input wire logic modem_irq_en,
	input wire logic fifo_en,
	input wire logic [1:0] fctl_tx_trig,
	input wire logic [1:0] fctl_rx_trig,
	input wire logic mctl_dtr,
	input wire logic mctl_rts,
	input wire logic mctl_op1,
	input wire logic mctl_op2,
	input wire logic loopback,
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic ring_indicator_n,
	input wire logic carrier_detect_n,
	input wire logic rx_pin,
	input wire logic bit_tick,
	input wire logic [3:0] frame_bits,
	input wire logic [6:0] rx_count,
	input wire logic rx_char_done,
	input wire logic head_par_err,
	input wire logic head_frm_err,
	input wire logic head_brk,
	input wire logic [6:0] rx_tagged_count,
	input wire logic [6:0] tx_count,
	input wire logic hold_full,
	input wire logic shift_busy,
	output logic baud_clk_en,
	output logic rx_push,
	output logic brk_push,
	output logic tx_hold,
	output logic rts_halt,
	output logic xoff_req,
	output logic xon_req,
	output logic modem_irq,
	output logic tx_ready_irq,
	output logic rx_data_irq,
	output logic rx_timeout_irq
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic presc;
		logic [1:0] pdiv;
		logic [7:0] scratch;
		logic [7:0] levels;
		logic [7:0] triggers;
		logic ovr;
		logic halted;
		uss_pkg::uss_brk_t bst;
		logic [3:0] bcnt;
		logic [7:0] idle;
		logic [1:0] rx_s;
		logic [7:0] rdata;
	} uss_state_t;

	uss_state_t s_q;
	uss_state_t s_d;

	logic [3:0] m_lvl;
	logic [3:0] m_delta;
	logic [3:0] pins_n;
	logic [3:0] loop_src;
	logic [3:0] rise_only;
	logic alt_sel;
	logic mstat_rd;
	logic lstat_rd;
	logic rx_line;
	logic [7:0] line_status;
	logic [7:0] modem_input_status;
	logic hold_empty;
	logic [6:0] halt_lvl;
	logic [6:0] resume_lvl;
	logic [6:0] tx_trig;
	logic [6:0] rx_trig;
	logic [6:0] tx_free;
	logic rx_full;

	// ****************************************
	// modem inputs
	// ****************************************
	assign pins_n = {carrier_detect_n, ring_indicator_n, dsr_n, cts_n};
	assign loop_src = {mctl_op2, mctl_op1, mctl_dtr, mctl_rts};
	assign rise_only = 4'h4;
	assign mstat_rd = reg_rd && !alt_sel &&
		reg_addr == uss_pkg::OFS_MODEM_STATUS;
	assign lstat_rd = reg_rd && reg_addr == uss_pkg::OFS_LINE_STATUS;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_modem
			uss_modem_bit u_bit (
				.clk(clk),
				.rstn(rstn),
				.pin_n(pins_n[gi]),
				.loop(loopback),
				.loop_lvl(loop_src[gi]),
				.rise_only(rise_only[gi]),
				.clr(mstat_rd),
				.lvl(m_lvl[gi]),
				.delta(m_delta[gi])
			);
		end
	endgenerate

	// ****************************************
	// decode and levels
	// ****************************************
	assign alt_sel = enh_enable && mctl_op1;
	assign rx_line = s_q.rx_s[1];
	assign rx_full = rx_count == uss_pkg::FIFO_DEPTH;
	assign hold_empty = fifo_en ? tx_count == 7'h00 : !hold_full;
	assign line_status = {
		rx_tagged_count != 7'h00,
		hold_empty && !shift_busy,
		hold_empty,
		head_brk && rx_count != 7'h00,
		head_frm_err && rx_count != 7'h00,
		head_par_err && rx_count != 7'h00,
		s_q.ovr,
		rx_count != 7'h00
	};
	assign modem_input_status = {m_lvl, m_delta};
	assign halt_lvl = {1'b0, s_q.levels[3:0], 2'b00};
	assign resume_lvl = {1'b0, s_q.levels[7:4], 2'b00};
	assign tx_free = uss_pkg::FIFO_DEPTH - tx_count;

	always_comb begin
		unique case (fctl_tx_trig)
			2'b00: tx_trig = uss_pkg::TX_TRIG_0;
			2'b01: tx_trig = uss_pkg::TX_TRIG_1;
			2'b10: tx_trig = uss_pkg::TX_TRIG_2;
			2'b11: tx_trig = uss_pkg::TX_TRIG_3;
		endcase
		if (s_q.triggers[3:0] != 4'h0)
			tx_trig = {1'b0, s_q.triggers[3:0], 2'b00};
		unique case (fctl_rx_trig)
			2'b00: rx_trig = uss_pkg::RX_TRIG_0;
			2'b01: rx_trig = uss_pkg::RX_TRIG_1;
			2'b10: rx_trig = uss_pkg::RX_TRIG_2;
			2'b11: rx_trig = uss_pkg::RX_TRIG_3;
		endcase
		if (s_q.triggers[7:4] != 4'h0)
			rx_trig = {1'b0, s_q.triggers[7:4], 2'b00};
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		brk_push = 1'b0;
		s_d.rx_s = {s_q.rx_s[0], rx_pin};
		// prescaler: free enable when undivided, one in four otherwise
		s_d.pdiv = s_q.pdiv + 2'h1;
		if (reg_wr && reg_addr == uss_pkg::OFS_MODEM_CONTROL && enh_enable)
			s_d.presc = reg_wdata[uss_pkg::PRESC_BIT];
		if (reg_wr && reg_addr == uss_pkg::OFS_MODEM_STATUS && alt_sel)
			s_d.levels = reg_wdata;
		if (reg_wr && reg_addr == uss_pkg::OFS_SCRATCH) begin
			if (alt_sel)
				s_d.triggers = reg_wdata;
			else
				s_d.scratch = reg_wdata;
		end
		// a new overrun in the reading cycle is kept
		if (rx_char_done && rx_full)
			s_d.ovr = 1'b1;
		else if (lstat_rd)
			s_d.ovr = 1'b0;
		// hysteresis between halt and resume levels
		if (rx_count >= halt_lvl)
			s_d.halted = 1'b1;
		else if (rx_count <= resume_lvl)
			s_d.halted = 1'b0;
		// line idle counter for the receive timeout
		if (!rx_line || rx_char_done || rx_count == 7'h00)
			s_d.idle = 8'h00;
		else if (bit_tick && s_q.idle != uss_pkg::RX_TIMEOUT_BITS)
			s_d.idle = s_q.idle + 8'h01;
		// break: one character per low period, however long
		unique case (s_q.bst)
			uss_pkg::USS_BRK_IDLE: begin
				s_d.bcnt = 4'h0;
				if (!rx_line)
					s_d.bst = uss_pkg::USS_BRK_LOW;
			end
			uss_pkg::USS_BRK_LOW: begin
				if (rx_line) begin
					s_d.bst = uss_pkg::USS_BRK_IDLE;
				end else if (bit_tick) begin
					s_d.bcnt = s_q.bcnt + 4'h1;
					if (s_q.bcnt + 4'h1 >= frame_bits) begin
						brk_push = 1'b1;
						s_d.bst = uss_pkg::USS_BRK_HELD;
					end
				end
			end
			uss_pkg::USS_BRK_HELD: begin
				if (rx_line)
					s_d.bst = uss_pkg::USS_BRK_IDLE;
			end
			default: s_d.bst = uss_pkg::USS_BRK_IDLE;
		endcase
		// read data: registered, valid the cycle after reg_rd
		if (reg_rd) begin
			unique case (reg_addr)
				uss_pkg::OFS_LINE_STATUS: s_d.rdata = line_status;
				uss_pkg::OFS_MODEM_STATUS:
					s_d.rdata = alt_sel ? s_q.levels : modem_input_status;
				uss_pkg::OFS_SCRATCH:
					s_d.rdata = alt_sel ? s_q.triggers : s_q.scratch;
				uss_pkg::OFS_MODEM_CONTROL:
					s_d.rdata = {s_q.presc, 7'h00};
				default: s_d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
			s_q.scratch <= uss_pkg::SCRATCH_RESET;
			s_q.levels <= uss_pkg::LEVELS_RESET;
			s_q.triggers <= uss_pkg::LEVELS_RESET;
			s_q.rx_s <= '1; // line idles high, no false break
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign reg_rdata = s_q.rdata;
	assign baud_clk_en = !s_q.presc || s_q.pdiv == uss_pkg::PRESC_LAST;
	assign rx_push = rx_char_done && !rx_full;
	// sampled by the transmitter only between characters
	assign tx_hold = auto_cts_en && !m_lvl[0];
	assign rts_halt = auto_rts_en && s_q.halted;
	assign xoff_req = sw_flow_en && s_d.halted && !s_q.halted;
	assign xon_req = sw_flow_en && !s_d.halted && s_q.halted;
	assign modem_irq = modem_irq_en && |m_delta;
	assign tx_ready_irq = tx_free >= tx_trig;
	assign rx_data_irq = rx_count >= rx_trig;
	assign rx_timeout_irq = rx_count != 7'h00 &&
		s_q.idle == uss_pkg::RX_TIMEOUT_BITS;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	chk_presc_rate: assert property (
		s_q.presc && baud_clk_en |=> (!baud_clk_en || !s_q.presc) [*3])
		else $error("divided baud enable too frequent");
	chk_overrun_set: assert property (
		rx_char_done && rx_full |-> !rx_push ##1 line_status[1])
		else $error("overrun not flagged or fifo written");
	chk_ovr_clear: assert property (
		lstat_rd && !(rx_char_done && rx_full) |=> !s_q.ovr)
		else $error("overrun not cleared by read");
	chk_idle_flag: assert property (
		line_status[6] |-> line_status[5] && !shift_busy)
		else $error("idle while transmitter busy");
	chk_scratch_keep: assert property (
		!reg_wr |=> $stable(s_q.scratch))
		else $error("scratch changed without write");
	chk_level_lock: assert property (
		!enh_enable |=> $stable(s_q.levels) && $stable(s_q.triggers))
		else $error("level register written while locked");
	chk_halt_level: assert property (
		auto_rts_en && rx_count >= halt_lvl |=> rts_halt)
		else $error("no halt at halt level");
	chk_resume_level: assert property (
		auto_rts_en && rx_count <= resume_lvl && rx_count < halt_lvl
		|=> !rts_halt)
		else $error("no resume at resume level");
	chk_rx_trig: assert property (
		s_q.triggers[7:4] != 4'h0 && rx_count ==
		{1'b0, s_q.triggers[7:4], 2'b00} |-> rx_data_irq)
		else $error("receive trigger missed");
	chk_tmo_needs_byte: assert property (
		rx_timeout_irq |-> rx_count != 7'h00 && $past(rx_line))
		else $error("timeout without data or idle line");
	chk_single_break: assert property (
		brk_push |=> !brk_push until rx_line)
		else $error("second break character in one low period");
	chk_msr_clear: assert property (
		mstat_rd |=> m_delta == 4'h0 || $changed(m_lvl))
		else $error("deltas not cleared by read");

endmodule : uss_status_flow
